/* File: src/mode_pkg.sv */
// package: mode codes, selector fields and sizes for the servo mode selector
package mode_pkg;
	// ==================================================
	// mode codes
	localparam logic [7:0] MODE_PULSE = 8'h00;
	localparam logic [7:0] MODE_STORED = 8'h01;
	localparam logic [7:0] MODE_SPEED = 8'h02;
	localparam logic [7:0] MODE_TORQUE = 8'h03;
	localparam logic [7:0] MODE_SPEED_INT = 8'h04;
	localparam logic [7:0] MODE_TORQUE_INT = 8'h05;
	localparam logic [7:0] MODE_PULSE_OR_SPEED = 8'h06;
	localparam logic [7:0] MODE_PULSE_OR_TORQUE = 8'h07;
	localparam logic [7:0] MODE_STORED_OR_SPEED = 8'h08;
	localparam logic [7:0] MODE_STORED_OR_TORQUE = 8'h09;
	localparam logic [7:0] MODE_S_T = 8'h0a;
	localparam logic [7:0] MODE_RESERVED = 8'h0b;
	localparam logic [7:0] MODE_NETWORK = 8'h0c;
	localparam logic [7:0] MODE_PULSE_OR_STORED = 8'h0d;
	localparam logic [7:0] MODE_PULSE_STORED_SPEED = 8'h0e;
	localparam logic [7:0] MODE_PULSE_STORED_TORQUE = 8'h0f;
	// ==================================================
	// sizes
	localparam int STORED_ENTRIES = 99;
	localparam int INT_ENTRIES = 3;
	localparam int DATA_W = 32;
	localparam int SEL_W = 7;
	// internal entry select code 0 picks the analog input where allowed
	localparam logic [1:0] SEL_ANALOG = 2'h0;
	// ==================================================
	// active control loop (one-hot)
	typedef enum logic [4:0] {
		LOOP_NONE = 5'b00001,
		LOOP_POS = 5'b00010,
		LOOP_SPEED = 5'b00100,
		LOOP_TORQUE = 5'b01000,
		LOOP_NET = 5'b10000
	} loop_t;
	// position command source
	typedef enum logic [1:0] {
		POS_PULSE = 2'h1,
		POS_STORED = 2'h2
	} pos_src_t;
endpackage : mode_pkg

/* File: src/mode_if.sv */
// interface: decoded mode choice passed from decoder to the main selector
`timescale 1ns/1ps
`default_nettype none
interface mode_if;
	import mode_pkg::*;
	logic valid; // code is listed and legal
	logic allow_pos_pulse; // pulse position reachable
	logic allow_pos_stored; // stored position reachable
	logic allow_speed; // speed reachable
	logic allow_torque; // torque reachable
	logic allow_analog; // analog source allowed
	logic network; // network controller mode
	modport dec (output valid, allow_pos_pulse, allow_pos_stored, allow_speed,
		allow_torque, allow_analog, network);
	modport use_ (input valid, allow_pos_pulse, allow_pos_stored, allow_speed,
		allow_torque, allow_analog, network);
endinterface : mode_if
`default_nettype wire

/* File: src/mode_decode.sv */
// module: mode code to capability decoder
`timescale 1ns/1ps
`default_nettype none
module mode_decode (
	input wire logic [7:0] mode_code,
	mode_if.dec m
);
	import mode_pkg::*;
	// ==================================================
	// combinational decode of each code's reachable loops
	always_comb
	begin
		m.valid = 1'b1;
		m.allow_pos_pulse = 1'b0;
		m.allow_pos_stored = 1'b0;
		m.allow_speed = 1'b0;
		m.allow_torque = 1'b0;
		m.allow_analog = 1'b0;
		m.network = 1'b0;
		unique case (mode_code)
			MODE_PULSE: m.allow_pos_pulse = 1'b1;
			MODE_STORED: m.allow_pos_stored = 1'b1;
			MODE_SPEED:
			begin
				m.allow_speed = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_SPEED_INT: m.allow_speed = 1'b1;
			MODE_TORQUE:
			begin
				m.allow_torque = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_TORQUE_INT: m.allow_torque = 1'b1;
			MODE_NETWORK: m.network = 1'b1;
			MODE_PULSE_OR_SPEED:
			begin
				m.allow_pos_pulse = 1'b1;
				m.allow_speed = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_PULSE_OR_TORQUE:
			begin
				m.allow_pos_pulse = 1'b1;
				m.allow_torque = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_STORED_OR_SPEED:
			begin
				m.allow_pos_stored = 1'b1;
				m.allow_speed = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_STORED_OR_TORQUE:
			begin
				m.allow_pos_stored = 1'b1;
				m.allow_torque = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_S_T:
			begin
				m.allow_speed = 1'b1;
				m.allow_torque = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_PULSE_OR_STORED:
			begin
				m.allow_pos_pulse = 1'b1;
				m.allow_pos_stored = 1'b1;
			end
			MODE_PULSE_STORED_SPEED:
			begin
				m.allow_pos_pulse = 1'b1;
				m.allow_pos_stored = 1'b1;
				m.allow_speed = 1'b1;
				m.allow_analog = 1'b1;
			end
			MODE_PULSE_STORED_TORQUE:
			begin
				m.allow_pos_pulse = 1'b1;
				m.allow_pos_stored = 1'b1;
				m.allow_torque = 1'b1;
				m.allow_analog = 1'b1;
			end
			// reserved and unlisted codes
			default: m.valid = 1'b0;
		endcase
	end
endmodule : mode_decode
`default_nettype wire

/* File: src/pulse_follow.sv */
// module: pulse/direction follower accumulating a position target
`timescale 1ns/1ps
`default_nettype none
module pulse_follow #(
	parameter int W = 32
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic enable,
	input wire logic one_to_one,
	input wire logic [15:0] gear_num,
	input wire logic step_s,
	input wire logic dir_s,
	output logic [W-1:0] target
);
	import mode_pkg::*;
	logic step_d1_q; // previous synced step level
	logic [W-1:0] target_q; // accumulated target
	logic [W-1:0] inc; // per-pulse increment
	// ==================================================
	// gearing: unit step when following one-for-one, else ratio step
	assign inc = one_to_one ? W'(1) : W'(gear_num);
	// ==================================================
	// rising-edge detect on the already synchronised step
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			step_d1_q <= 1'b0;
		else
			step_d1_q <= step_s;
	end
	// accumulate on each step while the pulse source is in use
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			target_q <= '0;
		else if (enable && step_s && !step_d1_q)
		begin
			if (dir_s)
				target_q <= target_q - inc;
			else
				target_q <= target_q + inc;
		end
	end
	assign target = target_q;
endmodule : pulse_follow
`default_nettype wire

/* File: src/servo_mode_selector.sv */
// module: servo operating-mode selector routing command sources to loops
// What this block does
// - mode 00: pulse input sets position target
// - pulse following configurable one-for-one gearing
// - mode 01: target from 99 stored entries
// - entry chosen by inputs or communication
// - mode 02: speed from entries or analog
// - mode 04: internal speed only, analog ignored
// - mode 03: torque from entries or analog
// - mode 05: internal torque only, analog ignored
// - mode 0C: network controller issues commands
// - 06/07: pulse position versus speed/torque switching
// - 08/09: stored position versus speed/torque switching
// - 0A: speed versus torque by input
// - 0D: pulse versus stored position by input
// - 0E/0F: inputs pick among three loops
// - multi mode is dual pair plus single
`timescale 1ns/1ps
`default_nettype none
module servo_mode_selector #(
	parameter int W = mode_pkg::DATA_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] mode_code,
	input wire logic servo_on,
	input wire logic pulse_step,
	input wire logic pulse_dir,
	input wire logic pulse_one_to_one,
	input wire logic [15:0] pulse_gear,
	input wire logic [mode_pkg::SEL_W-1:0] discrete_input_entry,
	input wire logic [mode_pkg::SEL_W-1:0] comm_entry,
	input wire logic comm_entry_use,
	input wire logic [1:0] discrete_input_cmd_sel,
	input wire logic [1:0] discrete_input_loop_sel,
	input wire logic [W-1:0] stored_position [mode_pkg::STORED_ENTRIES],
	input wire logic [W-1:0] speed_entry [mode_pkg::INT_ENTRIES],
	input wire logic [W-1:0] torque_entry [mode_pkg::INT_ENTRIES],
	input wire logic [W-1:0] analog_value,
	input wire logic [W-1:0] net_command,
	input wire logic net_valid,
	output logic motion_enable,
	output logic config_error,
	output logic [4:0] active_loop,
	output logic [W-1:0] position_target,
	output logic [W-1:0] speed_target,
	output logic [W-1:0] torque_target,
	output logic [W-1:0] net_target
);
	import mode_pkg::*;
	// ==================================================
	// elaboration checks
	// the gear step is a 16-bit count, so the target needs at least that much room
	if (W < 16)
	begin : g_bad_w
		$error("data width too small for gearing ratio");
	end
	// the entry index must be able to name every stored entry
	if ((2 ** SEL_W) < STORED_ENTRIES)
	begin : g_bad_sel
		$error("entry index too narrow for the stored table");
	end
	// the command fetch below serves exactly three internal entries
	if (INT_ENTRIES != 3)
	begin : g_bad_int
		$error("internal entry count not served by the command fetch");
	end
	// ==================================================
	// input synchronisers (two flops each)
	// step, direction, entry, use flag and select pins cross here, servo_on does not; mode_code and the tables are on clk_sys already
	// widths: step, dir, two entry indices, use flag, two 2-bit selects
	localparam int NSYNC = 2 + 2 * SEL_W + 5;
	logic [NSYNC-1:0] raw; // raw pin levels
	logic [NSYNC-1:0] s1_q; // first stage, only read by s2_q
	logic [NSYNC-1:0] s2_q; // synchronised levels
	assign raw = {pulse_step, pulse_dir, discrete_input_entry, comm_entry, comm_entry_use,
		discrete_input_cmd_sel, discrete_input_loop_sel};
	// two flops per pin; a metastable first stage never reaches logic
	// reset clears both stages so no stale level survives into the first run cycle
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end
	// synchronised levels, unpacked in the same order as raw above
	// a multi-bit select may show a mix of old and new bits for one cycle;
	// the loop register then follows the settled value on the next edge
	logic step_s; // step pin
	logic dir_s; // direction pin
	logic [SEL_W-1:0] entry_pin_s; // entry index from the inputs
	logic [SEL_W-1:0] comm_entry_s;
	logic comm_use_s;
	logic [1:0] cmd_sel_s;
	logic [1:0] loop_sel_s;
	assign {step_s, dir_s, entry_pin_s, comm_entry_s, comm_use_s, cmd_sel_s, loop_sel_s} = s2_q;
	// ==================================================
	// mode decoding
	// the decoder is purely combinational; its flags feed the next-loop logic and
	// the analog gate, and the loop register below keeps code glitches off the outputs
	// mode_code is already on clk_sys, so it is decoded without synchronisers
	mode_if mif ();
	mode_decode u_dec (
		.mode_code(mode_code),
		.m(mif)
	);
	// ==================================================
	// choose the wanted loop from the loop select inputs
	// multi modes: loop_sel 0 = pulse position, 1 = stored, 2/3 = third loop
	// dual with position (06-09): sel 0 keeps position, any nonzero sel takes the other leg
	// speed or torque (0a): sel[0] low is speed, high is torque
	// pulse or stored (0d): loop stays position, pick_pos chooses the source
	function automatic loop_t pick_loop(input logic [1:0] sel, input logic pp,
		input logic ps, input logic sp, input logic tq);
		loop_t r;
		logic want_pos;
		r = LOOP_POS;
		want_pos = pp || ps;
		if (want_pos && (sp || tq))
		begin
			// dual or multi with a speed/torque leg; either bit picks the leg in dual modes, only the top bit in multi
			if (sel[1] || (!(pp && ps) && sel[0]))
				r = sp ? LOOP_SPEED : LOOP_TORQUE;
		end
		else if (sp && tq)
			r = sel[0] ? LOOP_TORQUE : LOOP_SPEED;
		else if (sp)
			r = LOOP_SPEED;
		else if (tq)
			r = LOOP_TORQUE;
		return r;
	endfunction : pick_loop
	// stored vs pulse position choice when both are reachable
	// single position modes ignore the select pins
	function automatic pos_src_t pick_pos(input logic [1:0] sel, input logic pp,
		input logic ps);
		pos_src_t r;
		r = ps ? POS_STORED : POS_PULSE;
		if (pp && ps)
			r = sel[0] ? POS_STORED : POS_PULSE;
		return r;
	endfunction : pick_pos
	// ==================================================
	// loop and source state, changed only on the clock edge
	// loop_q and pos_src_q follow the decoded mode and the synchronised loop select
	loop_t loop_q;
	loop_t loop_d;
	pos_src_t pos_src_q;
	pos_src_t pos_src_d;
	logic err_q; // configuration error flag
	// next loop: an invalid code wins over everything, then network, then the pins
	always_comb
	begin
		loop_d = LOOP_NONE;
		pos_src_d = pos_src_q;
		if (!mif.valid)
			loop_d = LOOP_NONE;
		else if (mif.network)
			loop_d = LOOP_NET;
		else
		begin
			loop_d = pick_loop(loop_sel_s, mif.allow_pos_pulse, mif.allow_pos_stored,
				mif.allow_speed, mif.allow_torque);
			pos_src_d = pick_pos(loop_sel_s, mif.allow_pos_pulse,
				mif.allow_pos_stored);
		end
	end
	// registered loop switch: old and new sources never mix in one cycle
	// the position source switches on the same edge as the loop
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			loop_q <= LOOP_NONE;
			pos_src_q <= POS_PULSE;
		end
		else
		begin
			loop_q <= loop_d;
			pos_src_q <= pos_src_d;
		end
	end
	// error flag follows the mode code validity
	// not sticky: a good code clears it on the same edge that restores a loop
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			err_q <= 1'b0;
		else
			err_q <= !mif.valid;
	end
	// ==================================================
	// pulse position follower
	// the follower only counts while it owns the position target, so pulses that
	// arrive in another loop are dropped rather than replayed on a later switch
	logic [W-1:0] pulse_target;
	pulse_follow #(
		.W(W)
	) u_pulse (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.enable(loop_q == LOOP_POS && pos_src_q == POS_PULSE),
		.one_to_one(pulse_one_to_one),
		.gear_num(pulse_gear),
		.step_s(step_s),
		.dir_s(dir_s),
		.target(pulse_target)
	);
	// ==================================================
	// stored entry index: communication selection overrides inputs
	logic [SEL_W-1:0] entry_idx;
	// an index past the table end is ignored below and the old target stands
	assign entry_idx = comm_use_s ? comm_entry_s : entry_pin_s;
	// internal entry fetch; code 0 is analog where allowed
	// sel codes 1..3 pick entries 0..2; code 0 falls through to analog or entry 0
	function automatic logic [W-1:0] pick_cmd(input logic [1:0] sel, input logic an_ok,
		input logic [W-1:0] an, input logic [W-1:0] e0, input logic [W-1:0] e1,
		input logic [W-1:0] e2);
		logic [W-1:0] r;
		unique case (sel)
			2'h1: r = e0;
			2'h2: r = e1;
			2'h3: r = e2;
			default: r = an_ok ? an : e0;
		endcase
		return r;
	endfunction : pick_cmd
	// ==================================================
	// output targets, all registered
	// each target holds its last value while its loop is inactive
	logic [W-1:0] pos_q;
	logic [W-1:0] spd_q;
	logic [W-1:0] trq_q;
	logic [W-1:0] net_q;
	// position target from active position source
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			pos_q <= '0;
		else if (loop_q == LOOP_POS)
		begin
			if (pos_src_q == POS_PULSE)
				pos_q <= pulse_target;
			else if (int'(entry_idx) < STORED_ENTRIES)
				pos_q <= stored_position[entry_idx];
		end
	end
	// speed target; analog only in modes that allow it
	// the analog gate comes from the decoder, not the pins
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			spd_q <= '0;
		else if (loop_q == LOOP_SPEED)
			spd_q <= pick_cmd(cmd_sel_s, mif.allow_analog, analog_value, speed_entry[0],
				speed_entry[1], speed_entry[2]);
	end
	// torque target; analog only in modes that allow it
	// same gate as the speed path; both read the one synchronised command select
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			trq_q <= '0;
		else if (loop_q == LOOP_TORQUE)
			trq_q <= pick_cmd(cmd_sel_s, mif.allow_analog, analog_value, torque_entry[0],
				torque_entry[1], torque_entry[2]);
	end
	// network command latched on each valid cyclic update
	// a command offered outside the network loop is dropped, not queued
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			net_q <= '0;
		else if (loop_q == LOOP_NET && net_valid)
			net_q <= net_command;
	end
	// ==================================================
	// outputs
	// motion_enable is combinational from servo_on so a drop of servo_on stops
	// motion in the same cycle; the other outputs all come straight from flops
	// limitation: the block only routes targets and does not ramp between them, so
	// a loop switch hands the new loop its own last target, and the pulse follower
	// resumes from where it stopped when position control comes back
	assign motion_enable = servo_on && !err_q && loop_q != LOOP_NONE;
	assign config_error = err_q;
	assign active_loop = loop_q;
	assign position_target = pos_q;
	assign speed_target = spd_q;
	assign torque_target = trq_q;
	assign net_target = net_q;
endmodule : servo_mode_selector
`default_nettype wire

/* File: sim/servo_mode_sva.sv */
// checker: port-level assertions for the servo mode selector
`timescale 1ns/1ps
`default_nettype none
module servo_mode_sva #(
	parameter int W = 32
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] mode_code,
	input wire logic servo_on,
	input wire logic [W-1:0] net_command,
	input wire logic net_valid,
	input wire logic motion_enable,
	input wire logic config_error,
	input wire logic [4:0] active_loop,
	input wire logic [W-1:0] net_target
);
	default clocking cb @(posedge clk_sys);
	endclocking
	// two run edges after reset before any check: the registered outputs still show
	// their reset values at the first edge after release
	logic [1:0] run_q;
	always_ff @(posedge clk_sys)
	begin
		run_q <= {run_q[0], resetn};
	end
	default disable iff (!resetn || !run_q[1]);
	// ==================================================
	// sequences
	// reserved or unlisted code on the mode input
	sequence bad_code;
		mode_code == 8'h0b || mode_code > 8'h0f;
	endsequence
	// a network command offered while the network loop owns the targets
	sequence net_take;
		active_loop == 5'h10 ##0 net_valid;
	endsequence
	// ==================================================
	// assertions
	invalid_refuse_a: assert property (bad_code |=> config_error && active_loop == 5'h01)
		else $error("invalid code not refused");
	valid_clear_a: assert property (!(mode_code == 8'h0b || mode_code > 8'h0f) |=> !config_error)
		else $error("valid code flagged");
	motion_gate_a: assert property (motion_enable == (servo_on && !config_error && active_loop != 5'h01))
		else $error("motion enable gating wrong");
	pos_loop_a: assert property (mode_code inside {8'h00, 8'h01} |=> active_loop == 5'h02)
		else $error("position loop not chosen");
	speed_loop_a: assert property (mode_code inside {8'h02, 8'h04} |=> active_loop == 5'h04)
		else $error("speed loop not chosen");
	torque_loop_a: assert property (mode_code inside {8'h03, 8'h05} |=> active_loop == 5'h08)
		else $error("torque loop not chosen");
	net_loop_a: assert property (mode_code == 8'h0c |=> active_loop == 5'h10)
		else $error("network loop not chosen");
	one_loop_a: assert property ($onehot(active_loop)
		&& (config_error == (active_loop == 5'h01)))
		else $error("loop select not one-hot or not matched to error flag");
	net_take_a: assert property (net_take |=> net_target == $past(net_command))
		else $error("network command not taken");
	net_hold_a: assert property (!(active_loop == 5'h10 && net_valid) |=> $stable(net_target))
		else $error("network target moved without command");
endmodule : servo_mode_sva
bind servo_mode_selector servo_mode_sva #(.W(W)) CHK (.clk_sys(clk_sys), .resetn(resetn),
	.mode_code(mode_code), .servo_on(servo_on), .net_command(net_command), .net_valid(net_valid),
	.motion_enable(motion_enable), .config_error(config_error), .active_loop(active_loop),
	.net_target(net_target));
`default_nettype wire

/* File: sim/far_side.sv */
// model: discrete inputs, pulse source and network controller on the far side
`timescale 1ns/1ps
`default_nettype none
module far_side (
	input wire logic clk_sys,
	output logic pulse_step,
	output logic pulse_dir,
	output logic [1:0] loop_sel,
	output logic [1:0] cmd_sel,
	output logic [6:0] entry,
	output logic [31:0] net_command,
	output logic net_valid
);
	// ==================================================
	// idle levels
	initial
	begin
		pulse_step = 1'b0;
		pulse_dir = 1'b0;
		loop_sel = 2'h0;
		cmd_sel = 2'h0;
		entry = 7'h00;
		net_command = 32'h0;
		net_valid = 1'b0;
	end
	// steps held three cycles high and four low so the synchroniser sees every edge
	task steps(input int n, input logic dn);
		@(posedge clk_sys);
		pulse_dir <= dn;
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_sys);
			pulse_step <= 1'b1;
			repeat (3) @(posedge clk_sys);
			pulse_step <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
	endtask : steps
	// binary-weighted selector pins
	task sel(input logic [1:0] l, input logic [1:0] c, input logic [6:0] e);
		@(posedge clk_sys);
		loop_sel <= l;
		cmd_sel <= c;
		entry <= e;
	endtask : sel
	// one cyclic command; data is scrambled once valid drops
	task net_send(input logic [31:0] v);
		@(posedge clk_sys);
		net_command <= v;
		net_valid <= 1'b1;
		@(posedge clk_sys);
		net_valid <= 1'b0;
		net_command <= ~v;
	endtask : net_send
endmodule : far_side
`default_nettype wire

/* File: sim/servo_mode_selector_tb.sv */
// testbench: directed scenarios for the servo mode selector
`timescale 1ns/1ps
`default_nettype none
module servo_mode_selector_tb;
	import mode_pkg::*;
	logic clk_sys, resetn, servo_on, step, dir, one_to_one, comm_use, net_valid;
	logic motion_enable, config_error;
	logic [7:0] mode_code;
	logic [15:0] gear;
	logic [6:0] pin_entry, comm_entry;
	logic [1:0] cmd_sel, loop_sel;
	logic [31:0] stored [99];
	logic [31:0] spd [3];
	logic [31:0] trq [3];
	logic [31:0] analog, net_cmd, pos_t, spd_t, trq_t, net_t;
	logic [4:0] active_loop;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	// ==================================================
	// clock and design
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	servo_mode_selector DUT (.clk_sys(clk_sys), .resetn(resetn), .mode_code(mode_code),
		.servo_on(servo_on), .pulse_step(step), .pulse_dir(dir), .pulse_one_to_one(one_to_one),
		.pulse_gear(gear), .discrete_input_entry(pin_entry), .comm_entry(comm_entry),
		.comm_entry_use(comm_use), .discrete_input_cmd_sel(cmd_sel),
		.discrete_input_loop_sel(loop_sel), .stored_position(stored), .speed_entry(spd),
		.torque_entry(trq), .analog_value(analog), .net_command(net_cmd), .net_valid(net_valid),
		.motion_enable(motion_enable), .config_error(config_error), .active_loop(active_loop),
		.position_target(pos_t), .speed_target(spd_t), .torque_target(trq_t), .net_target(net_t));
	far_side FAR (.clk_sys(clk_sys), .pulse_step(step), .pulse_dir(dir), .loop_sel(loop_sel),
		.cmd_sel(cmd_sel), .entry(pin_entry), .net_command(net_cmd), .net_valid(net_valid));
	// ==================================================
	// helpers
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// new mode code, then let sync, loop and target stages land
	task setm(input logic [7:0] c);
		@(posedge clk_sys);
		mode_code <= c;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : setm
	task results;
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	// hang guard: the whole run needs well under 2000 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			results();
		end
	end
	// ==================================================
	// scenarios
	task pulse_mode;
		setm(8'h00);
		FAR.steps(3, 1'b0);
		setm(8'h00);
		chk("pulse 1:1", 32'h3, pos_t);
		one_to_one <= 1'b0;
		FAR.steps(2, 1'b1);
		setm(8'h00);
		chk("pulse gear", 32'hffff_fff9, pos_t);
	endtask : pulse_mode
	task stored_mode;
		FAR.sel(2'h0, 2'h0, 7'd98);
		setm(8'h01);
		chk("entry 98", stored[98], pos_t);
		comm_entry <= 7'd5;
		comm_use <= 1'b1;
		setm(8'h01);
		chk("comm entry", stored[5], pos_t);
		comm_entry <= 7'd99;
		setm(8'h01);
		chk("entry 99", stored[5], pos_t);
		comm_use <= 1'b0;
	endtask : stored_mode
	task automatic source_modes;
		logic [7:0] cd [6] = '{8'h02, 8'h02, 8'h04, 8'h03, 8'h03, 8'h05};
		logic [1:0] cs [6] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h3, 2'h0};
		logic [31:0] ex [6];
		ex = '{analog, spd[1], spd[0], analog, trq[2], trq[0]};
		for (int i = 0; i < 6; i++)
		begin
			FAR.sel(2'h0, cs[i], 7'd0);
			setm(cd[i]);
			chk("command source", ex[i], (i < 3) ? spd_t : trq_t);
		end
	endtask : source_modes
	task automatic switch_modes;
		logic [7:0] cd [12] = '{8'h06, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0a, 8'h0d, 8'h0d,
			8'h0e, 8'h0f, 8'h0e};
		logic [1:0] ls [12] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2,
			2'h1};
		logic [4:0] ex [12] = '{5'h02, 5'h04, 5'h08, 5'h02, 5'h08, 5'h04, 5'h08, 5'h02, 5'h02,
			5'h04, 5'h08, 5'h02};
		for (int i = 0; i < 12; i++)
		begin
			FAR.sel(ls[i], 2'h0, 7'd0);
			setm(cd[i]);
			chk("switched loop", {27'h0, ex[i]}, {27'h0, active_loop});
			if (cd[i] == 8'h0d)
				chk("position source", ls[i][0] ? stored[0] : 32'hffff_fff9, pos_t);
		end
	endtask : switch_modes
	task network_mode;
		setm(8'h0c);
		FAR.net_send(32'h1234_5678);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("net target", 32'h1234_5678, net_t);
		setm(8'h00);
		FAR.net_send(32'h0bad_0bad);
		setm(8'h00);
		chk("net ignored", 32'h1234_5678, net_t);
	endtask : network_mode
	task automatic refused;
		logic [7:0] cd [3] = '{8'h0b, 8'h10, 8'hff};
		for (int i = 0; i < 3; i++)
		begin
			setm(cd[i]);
			chk("error flag", 32'h1, {31'h0, config_error});
			chk("motion off", 32'h0, {31'h0, motion_enable});
			chk("loop none", 32'h1, {27'h0, active_loop});
		end
		setm(8'h02);
		chk("error clear", 32'h0, {31'h0, config_error});
		chk("motion on", 32'h1, {31'h0, motion_enable});
		servo_on <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("servo off", 32'h0, {31'h0, motion_enable});
		servo_on <= 1'b1;
	endtask : refused
	// ==================================================
	// main sequence
	initial
	begin
		resetn = 1'b0;
		mode_code = 8'h00;
		servo_on = 1'b1;
		one_to_one = 1'b1;
		gear = 16'h0005;
		comm_use = 1'b0;
		comm_entry = 7'h00;
		analog = 32'h0000_a5a5;
		for (int i = 0; i < 99; i++)
			stored[i] = 32'h1000 + i;
		for (int i = 0; i < 3; i++)
		begin
			spd[i] = 32'h200 + i;
			trq[i] = 32'h300 + i;
		end
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		pulse_mode();
		stored_mode();
		source_modes();
		switch_modes();
		network_mode();
		refused();
		results();
	end
endmodule : servo_mode_selector_tb
`default_nettype wire
